// File: logic/svq_ring_engine.sv
// split virtqueue available/used ring engine, device side
//
// Contract
// - available ring is driver-written; this engine only reads it
// - no event index: ignore threshold, notify when avail flags zero
// - event index: ignore flag bit, notify when used idx moves past threshold
// - used ring is device-written only; driver reads it
// - each used entry holds head id and bytes written
// - used index names next used slot, starts zero, only increases
// - write length and data before advancing used index
// - in-order: one entry per batch, index advances by batch size
// - in-order batch entry sits at batch's first slot
// - no event index: device keeps used flags at 0 or 1
// - event index: used flags zero, avail threshold may be written
// - device tolerates spurious available notifications
// - 16-bit indices wrap naturally; slots use wrapped values
// - queue size never exceeds 32768 entries
`timescale 1ns/1ps
`include "svq_map.svh"
module svq_ring_engine (
  input  wire logic                     mclk,
  input  wire logic                     rst_b,
  // configuration
  input  wire logic                     enable,
  input  wire logic                     featEventIdx,
  input  wire logic                     featInOrder,
  input  wire logic [15:0]              queueSize,
  input  wire logic [63:0]              availBase,
  input  wire logic [63:0]              usedBase,
  input  wire logic                     suppressAvailNote,
  input  wire logic [15:0]              availEventValue,
  // doorbell from the driver, asynchronous pin
  input  wire logic                     availNotifyPin,
  // memory port
  output svq_pkg::svq_mem_req_type      memReq,
  output logic                          memReqValid,
  input  wire logic                     memReqReady,
  input  wire logic [15:0]              memRdData,
  input  wire logic                     memRdValid,
  // offered heads toward the device core
  output logic [15:0]                   headOut,
  output logic                          headValid,
  input  wire logic                     headReady,
  // completions from the device core
  input  wire svq_pkg::svq_cpl_type     cplIn,
  input  wire logic                     cplValid,
  output logic                          cplReady,
  // status
  output logic                          usedNotify,
  output logic [15:0]                   usedIdxOut,
  output logic [15:0]                   lastAvailOut,
  output logic                          configError
);
  svq_pkg::svq_state_type stateReg;
  svq_pkg::svq_state_type stateNext;
  logic [15:0]            usedIdxReg;
  logic [15:0]            lastAvailReg;
  logic [15:0]            availIdxReg;
  logic [15:0]            availFlagsReg;
  logic [15:0]            usedEventReg;
  logic [15:0]            slotUsedReg;
  logic                   kickPendReg;
  logic                   initDoneReg;
  logic                   flagsDirtyReg;
  logic                   lastSupReg;
  wire                    kickPulse;
  wire                    fifoValid;
  wire                    fifoTake;
  svq_pkg::svq_cpl_type   fifoData;
  wire                    sizeOk;
  wire                    haveAvail;
  wire                    memFire;
  wire                    notifyDue;
  wire [15:0]             usedIdxAdv;
  wire [15:0]             usedFlagVal;

  // -------------------------------------------------------------
  // slot address helpers
  // -------------------------------------------------------------
  // slot from wrapped index
  function automatic logic [15:0] slotOf(input logic [15:0] idx,
                                         input logic [15:0] qs);
    slotOf = (qs == 16'h0000) ? 16'h0000 : idx % qs;
  endfunction

  function automatic logic [63:0] entAddr(input logic [63:0] base,
                                          input logic [15:0] slot,
                                          input int          shift);
    entAddr = base + 64'(`SVQ_RING_ENT_OFS) + (64'(slot) << shift);
  endfunction

  // -------------------------------------------------------------
  // submodules
  // -------------------------------------------------------------
  // doorbells only set a pending bit
  svq_notify_sync uNotify (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .pinIn     (availNotifyPin),
    .risePulse (kickPulse)
  );

  svq_fifo #(
    .WIDTH ($bits(svq_pkg::svq_cpl_type)),
    .DEPTH (`SVQ_FIFO_DEPTH),
    .AW    (`SVQ_FIFO_AW)
  ) uCplFifo (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .inValid  (cplValid),
    .inReady  (cplReady),
    .inData   (cplIn),
    .outValid (fifoValid),
    .outReady (fifoTake),
    .outData  (fifoData)
  );

  // -------------------------------------------------------------
  // decode
  // -------------------------------------------------------------
  // reject oversize or zero queue
  assign sizeOk    = (queueSize != 16'h0000) &&
                     (queueSize <= `SVQ_QSIZE_MAX);
  // avail ring consumed up to driver index
  assign haveAvail = (availIdxReg != lastAvailReg);
  assign memFire   = memReqValid && memReqReady;
  // index advance by batch size when in-order
  assign usedIdxAdv = 16'(usedIdxReg +
                      ((featInOrder && fifoData.count != 16'h0000) ?
                       fifoData.count : 16'h0001));
  // flag check; threshold inside the advanced span
  assign notifyDue = featEventIdx ?
                     (16'(usedIdxAdv - usedEventReg - 16'h0001) <
                      16'(usedIdxAdv - usedIdxReg)) :
                     (availFlagsReg[`SVQ_FLAG_NONOTE_BIT] == 1'b0);
  // flags only 0 or 1; 0 under event index
  assign usedFlagVal = (featEventIdx || !suppressAvailNote) ?
                       `SVQ_FLAGS_RESET : 16'h0001;
  assign fifoTake  = (stateReg == svq_pkg::SVQ_WR_UIDX) && memFire;

  // -------------------------------------------------------------
  // control state machine
  // -------------------------------------------------------------
  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      svq_pkg::SVQ_IDLE: begin
        if (enable && sizeOk) begin
          if (!initDoneReg || flagsDirtyReg)
            stateNext = svq_pkg::SVQ_WR_UFLG;
          else if (fifoValid)
            stateNext = svq_pkg::SVQ_RD_AFLG;
          else if (haveAvail && !headValid)
            stateNext = svq_pkg::SVQ_RD_ENT;
          else if (kickPendReg || !haveAvail)
            stateNext = svq_pkg::SVQ_RD_AIDX;
        end
      end
      svq_pkg::SVQ_WR_UFLG:
        if (memFire) stateNext = featEventIdx ? svq_pkg::SVQ_WR_AEVT :
                                                 svq_pkg::SVQ_IDLE;
      svq_pkg::SVQ_WR_AEVT:
        if (memFire) stateNext = svq_pkg::SVQ_IDLE;
      svq_pkg::SVQ_RD_AIDX:
        if (memRdValid) stateNext = svq_pkg::SVQ_IDLE;
      svq_pkg::SVQ_RD_ENT:
        if (memRdValid) stateNext = svq_pkg::SVQ_IDLE;
      svq_pkg::SVQ_RD_AFLG:
        if (memRdValid) stateNext = svq_pkg::SVQ_RD_UEVT;
      svq_pkg::SVQ_RD_UEVT:
        if (memRdValid) stateNext = svq_pkg::SVQ_WR_ID;
      svq_pkg::SVQ_WR_ID:
        if (memFire) stateNext = svq_pkg::SVQ_WR_LEN;
      svq_pkg::SVQ_WR_LEN:
        if (memFire) stateNext = svq_pkg::SVQ_WR_UIDX;
      svq_pkg::SVQ_WR_UIDX:
        if (memFire) stateNext = svq_pkg::SVQ_IDLE;
      default: stateNext = svq_pkg::SVQ_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) stateReg <= svq_pkg::SVQ_IDLE;
    else        stateReg <= stateNext;
  end

  // -------------------------------------------------------------
  // memory request generation, registered
  // -------------------------------------------------------------
  // used ring only written here, avail ring only read
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      memReqValid <= 1'b0;
      memReq      <= '0;
    end else if (memReqValid && !memReqReady) begin
      memReqValid <= 1'b1;               // hold until accepted
    end else begin
      memReqValid <= 1'b0;
      case (stateNext)
        svq_pkg::SVQ_RD_AIDX: if (stateReg != stateNext) begin
          memReqValid <= 1'b1;
          memReq.op   <= svq_pkg::SVQ_MEM_RD16;
          memReq.addr <= availBase + 64'(`SVQ_RING_IDX_OFS);
          memReq.data <= 32'h0000_0000;
        end
        svq_pkg::SVQ_RD_ENT: if (stateReg != stateNext) begin
          memReqValid <= 1'b1;
          memReq.op   <= svq_pkg::SVQ_MEM_RD16;
          memReq.addr <= entAddr(availBase,
                           slotOf(lastAvailReg, queueSize),
                           `SVQ_AVAIL_ENT_SHIFT);
          memReq.data <= 32'h0000_0000;
        end
        svq_pkg::SVQ_RD_AFLG: if (stateReg != stateNext) begin
          memReqValid <= 1'b1;
          memReq.op   <= svq_pkg::SVQ_MEM_RD16;
          memReq.addr <= availBase + 64'(`SVQ_RING_FLAGS_OFS);
          memReq.data <= 32'h0000_0000;
        end
        svq_pkg::SVQ_RD_UEVT: if (stateReg != stateNext) begin
          memReqValid <= 1'b1;
          memReq.op   <= svq_pkg::SVQ_MEM_RD16;
          memReq.addr <= entAddr(availBase, queueSize,
                                 `SVQ_AVAIL_ENT_SHIFT);
          memReq.data <= 32'h0000_0000;
        end
        // head id then length; at batch first slot
        svq_pkg::SVQ_WR_ID: if (stateReg != stateNext) begin
          memReqValid <= 1'b1;
          memReq.op   <= svq_pkg::SVQ_MEM_WR32;
          memReq.addr <= entAddr(usedBase, slotUsedReg,
                                 `SVQ_USED_ENT_SHIFT);
          memReq.data <= fifoData.head;
        end
        svq_pkg::SVQ_WR_LEN: if (stateReg != stateNext) begin
          memReqValid <= 1'b1;
          memReq.op   <= svq_pkg::SVQ_MEM_WR32;
          memReq.addr <= entAddr(usedBase, slotUsedReg,
                           `SVQ_USED_ENT_SHIFT) +
                         64'(`SVQ_USED_LEN_OFS);
          memReq.data <= fifoData.len;
        end
        svq_pkg::SVQ_WR_UIDX: if (stateReg != stateNext) begin
          memReqValid <= 1'b1;
          memReq.op   <= svq_pkg::SVQ_MEM_WR16;
          memReq.addr <= usedBase + 64'(`SVQ_RING_IDX_OFS);
          memReq.data <= {16'h0000, usedIdxAdv};
        end
        svq_pkg::SVQ_WR_UFLG: if (stateReg != stateNext) begin
          memReqValid <= 1'b1;
          memReq.op   <= svq_pkg::SVQ_MEM_WR16;
          memReq.addr <= usedBase + 64'(`SVQ_RING_FLAGS_OFS);
          memReq.data <= {16'h0000, usedFlagVal};
        end
        svq_pkg::SVQ_WR_AEVT: if (stateReg != stateNext) begin
          memReqValid <= 1'b1;
          memReq.op   <= svq_pkg::SVQ_MEM_WR16;
          memReq.addr <= entAddr(usedBase, queueSize,
                                 `SVQ_USED_ENT_SHIFT);
          memReq.data <= {16'h0000, availEventValue};
        end
        default: memReqValid <= 1'b0;
      endcase
    end
  end

  // -------------------------------------------------------------
  // ring snapshots from read data
  // -------------------------------------------------------------
  // threshold read only matters with event index
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      availIdxReg   <= `SVQ_IDX_RESET;
      availFlagsReg <= `SVQ_FLAGS_RESET;
      usedEventReg  <= `SVQ_IDX_RESET;
    end else if (memRdValid) begin
      if (stateReg == svq_pkg::SVQ_RD_AIDX) availIdxReg   <= memRdData;
      if (stateReg == svq_pkg::SVQ_RD_AFLG) availFlagsReg <= memRdData;
      if (stateReg == svq_pkg::SVQ_RD_UEVT) usedEventReg  <= memRdData;
    end
  end

  // -------------------------------------------------------------
  // indices and head hand-off
  // -------------------------------------------------------------
  // used index from zero, only forward
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      usedIdxReg   <= `SVQ_IDX_RESET;
      lastAvailReg <= `SVQ_IDX_RESET;
      slotUsedReg  <= 16'h0000;
      headOut      <= 16'h0000;
      headValid    <= 1'b0;
    end else begin
      slotUsedReg <= slotOf(usedIdxReg, queueSize);
      if (fifoTake) usedIdxReg <= usedIdxAdv;
      if (headValid && headReady) headValid <= 1'b0;
      if (memRdValid && stateReg == svq_pkg::SVQ_RD_ENT) begin
        headOut      <= memRdData;
        headValid    <= 1'b1;
        lastAvailReg <= 16'(lastAvailReg + 16'h0001);
      end
    end
  end

  // -------------------------------------------------------------
  // kick, setup and notify flags
  // -------------------------------------------------------------
  // kick set wins over the clear in the same cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      kickPendReg   <= 1'b0;
      initDoneReg   <= 1'b0;
      flagsDirtyReg <= 1'b0;
      lastSupReg    <= 1'b0;
      usedNotify    <= 1'b0;
    end else begin
      lastSupReg <= suppressAvailNote;
      if (kickPulse)
        kickPendReg <= 1'b1;
      else if (stateReg == svq_pkg::SVQ_RD_AIDX && memRdValid)
        kickPendReg <= 1'b0;
      if (!enable)
        initDoneReg <= 1'b0;
      else if (stateReg == svq_pkg::SVQ_WR_UFLG && memFire)
        initDoneReg <= 1'b1;
      if (suppressAvailNote != lastSupReg)
        flagsDirtyReg <= 1'b1;
      else if (stateReg == svq_pkg::SVQ_WR_UFLG && memFire)
        flagsDirtyReg <= 1'b0;
      // one pulse after the index write lands
      usedNotify <= fifoTake && notifyDue;
    end
  end

  // -------------------------------------------------------------
  // status outputs
  // -------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      usedIdxOut   <= 16'h0000;
      lastAvailOut <= 16'h0000;
      configError  <= 1'b0;
    end else begin
      usedIdxOut   <= usedIdxReg;
      lastAvailOut <= lastAvailReg;
      configError  <= enable && !sizeOk;
    end
  end
endmodule

// File: include/svq_map.svh
// register-free layout constants and reset values for the ring engine
`ifndef SVQ_MAP_SVH
`define SVQ_MAP_SVH

// ---------------------------------------------------------------
// ring layout: offsets from each ring base, entry shifts, length offset in a used entry
// ---------------------------------------------------------------
`define SVQ_RING_FLAGS_OFS  16'h0000
`define SVQ_RING_IDX_OFS    16'h0002
`define SVQ_RING_ENT_OFS    16'h0004
`define SVQ_AVAIL_ENT_SHIFT 1
`define SVQ_USED_ENT_SHIFT  3
`define SVQ_USED_LEN_OFS    16'h0004

// ---------------------------------------------------------------
// limits and reset values
// ---------------------------------------------------------------
`define SVQ_QSIZE_MAX       16'h8000
`define SVQ_IDX_RESET       16'h0000
`define SVQ_FLAGS_RESET     16'h0000
`define SVQ_FLAG_NONOTE_BIT 0
`define SVQ_FIFO_DEPTH      8
`define SVQ_FIFO_AW         3

`endif

// File: include/svq_pkg.sv
// types shared by the split ring engine files
package svq_pkg;

  // memory command issued to the host fabric
  typedef enum logic [1:0] {
    SVQ_MEM_RD16 = 2'b00,
    SVQ_MEM_WR16 = 2'b01,
    SVQ_MEM_WR32 = 2'b10
  } svq_mem_op_type;

  typedef struct packed {
    svq_mem_op_type op;
    logic [63:0]    addr;
    logic [31:0]    data;
  } svq_mem_req_type;

  // completion from the device core: head id, bytes written, batch size
  typedef struct packed {
    logic [31:0] head;
    logic [31:0] len;
    logic [15:0] count;
  } svq_cpl_type;

  typedef enum logic [3:0] {
    SVQ_IDLE    = 4'b0000,
    SVQ_RD_AIDX = 4'b0001,
    SVQ_RD_ENT  = 4'b0010,
    SVQ_WR_ID   = 4'b0011,
    SVQ_WR_LEN  = 4'b0100,
    SVQ_WR_UIDX = 4'b0101,
    SVQ_RD_AFLG = 4'b0110,
    SVQ_RD_UEVT = 4'b0111,
    SVQ_WR_UFLG = 4'b1000,
    SVQ_WR_AEVT = 4'b1001
  } svq_state_type;

endpackage

// File: logic/svq_fifo.sv
// small synchronous fifo in the completion path
`timescale 1ns/1ps
`include "svq_map.svh"
module svq_fifo #(
  parameter int WIDTH = 80,
  parameter int DEPTH = `SVQ_FIFO_DEPTH,
  parameter int AW    = `SVQ_FIFO_AW
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] memReg [DEPTH];
  logic [AW:0]      wrPtrReg;
  logic [AW:0]      rdPtrReg;
  wire              doWr;
  wire              doRd;
  wire [AW:0]       fillNext;
  wire              isFull;
  wire              isEmpty;

  // -------------------------------------------------------------
  // status decode
  // -------------------------------------------------------------
  assign isEmpty  = (wrPtrReg == rdPtrReg);
  assign isFull   = (wrPtrReg[AW] != rdPtrReg[AW]) &&
                    (wrPtrReg[AW-1:0] == rdPtrReg[AW-1:0]);
  // level after this edge, so that ready can come from a flop
  assign fillNext = (AW+1)'(wrPtrReg - rdPtrReg + doWr - doRd);
  assign outValid = !isEmpty;
  assign doWr     = inValid && !isFull;
  assign doRd     = outReady && !isEmpty;
  assign outData  = memReg[rdPtrReg[AW-1:0]];

  // storage has no reset; only pointers define contents
  always_ff @(posedge mclk) begin
    if (doWr) begin
      memReg[wrPtrReg[AW-1:0]] <= inData;
    end
  end

  // pointers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtrReg <= '0;
      rdPtrReg <= '0;
      inReady  <= 1'b0;
    end else begin
      inReady  <= (fillNext != (AW+1)'(DEPTH));
      if (doWr) wrPtrReg <= wrPtrReg + 1'b1;
      if (doRd) rdPtrReg <= rdPtrReg + 1'b1;
    end
  end
endmodule

// File: logic/svq_notify_sync.sv
// two-flop synchroniser and edge detector for the doorbell input
`timescale 1ns/1ps
module svq_notify_sync (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic pinIn,
  output logic      risePulse
);
  logic meta1Reg;
  logic meta2Reg;
  logic lastReg;

  // only meta2Reg reads the first stage
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta1Reg  <= 1'b0;
      meta2Reg  <= 1'b0;
      lastReg   <= 1'b0;
      risePulse <= 1'b0;
    end else begin
      meta1Reg  <= pinIn;
      meta2Reg  <= meta1Reg;
      lastReg   <= meta2Reg;
      risePulse <= meta2Reg && !lastReg;
    end
  end
endmodule

// File: verif/svq_ring_checker.sv
// port-level assertions for the split ring engine
`timescale 1ns/1ps
module svq_ring_checker (
  input wire logic                     mclk,
  input wire logic                     rst_b,
  input wire logic                     featEventIdx,
  input wire logic [15:0]              queueSize,
  input wire logic [63:0]              usedBase,
  input wire svq_pkg::svq_mem_req_type memReq,
  input wire logic                     memReqValid,
  input wire logic                     memReqReady,
  input wire logic [15:0]              headOut,
  input wire logic                     headValid,
  input wire logic                     headReady,
  input wire logic                     usedNotify,
  input wire logic [15:0]              usedIdxOut,
  input wire logic                     configError
);
  // decode used ring writes by their offset; flags write when requested, others when accepted
  wire        acc     = memReqValid && memReqReady;
  wire [63:0] ofs     = memReq.addr - usedBase;
  wire        isW16   = memReq.op == svq_pkg::SVQ_MEM_WR16;
  wire        isW32   = memReq.op == svq_pkg::SVQ_MEM_WR32;
  wire        uIdxAcc = acc && isW16 && ofs == 64'h2;
  wire        uFlgReq = memReqValid && isW16 && ofs == 64'h0;
  wire        idAcc   = acc && isW32 && ofs[2:0] == 3'h4;
  wire        lenAcc  = acc && isW32 && ofs[2:0] == 3'h0;
  logic       lenSeen_reg;

  // remembers a length write since the last index update
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) lenSeen_reg <= 1'b0;
    else if (uIdxAcc) lenSeen_reg <= 1'b0;
    else if (lenAcc) lenSeen_reg <= 1'b1;
  end

  sequence s_idAcc;
    idAcc;
  endsequence
  sequence s_lenAcc;
    lenAcc;
  endsequence

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_reset_quiet: assert property ($rose(rst_b) |->
    !memReqValid && !headValid && !usedNotify && usedIdxOut == 16'h0000)
    else $error("outputs not idle after reset");
  a_req_hold: assert property (memReqValid && !memReqReady |=>
    memReqValid && $stable(memReq)) else $error("memory request dropped");
  a_head_hold: assert property (headValid && !headReady |=>
    headValid && $stable(headOut)) else $error("offered head dropped");
  a_used_rise: assert property ($changed(usedIdxOut) |->
    16'(usedIdxOut - $past(usedIdxOut)) inside {[16'h0001:16'h8000]})
    else $error("used index went backwards");
  a_len_first: assert property (uIdxAcc |-> lenSeen_reg)
    else $error("used index before length");
  a_entry_pair: assert property (s_idAcc |-> ##[1:40] s_lenAcc)
    else $error("id written without length");
  a_note_cause: assert property (usedNotify |->
    $past(uIdxAcc) || $past(uIdxAcc, 2)) else $error("stray notification");
  a_note_pulse: assert property (usedNotify |=> !usedNotify)
    else $error("notification longer than a pulse");
  a_uflag_legal: assert property (uFlgReq |->
    memReq.data[15:0] <= 16'h0001) else $error("used flags out of range");
  a_uflag_zero: assert property (uFlgReq && featEventIdx |->
    memReq.data[15:0] == 16'h0000) else $error("used flags not zero");
  a_cfg_error: assert property (
    (queueSize == 16'h0000 || queueSize > 16'h8000) [*3] |-> configError)
    else $error("bad queue size not flagged");
endmodule

// File: verif/svq_guest_mem.sv
// guest memory model holding the driver's rings
`timescale 1ns/1ps
module svq_guest_mem (
  input  wire logic                     mclk,
  input  wire logic                     rst_b,
  input  wire logic                     slow,
  input  wire svq_pkg::svq_mem_req_type memReq,
  input  wire logic                     memReqValid,
  output logic                          memReqReady,
  output logic [15:0]                   memRdData,
  output logic                          memRdValid
);
  logic [15:0] mem [0:2047];
  logic        stall_reg;
  logic [15:0] last_reg = 16'h0000;
  wire  [10:0] wi = memReq.addr[11:1];

  // ready at once, or only every other cycle when slow
  assign memReqReady = memReqValid && !(slow && stall_reg);

  // driver zeroes both rings, used flags included
  task automatic clear();
    for (int i = 0; i < 2048; i++) mem[i] = 16'h0000;
  endtask

  // device writes land as halfwords, little end first
  always @(posedge mclk) begin
    memRdValid <= 1'b0;
    memRdData <= ~last_reg; // floating line: inverse, not a stale copy
    if (!rst_b) stall_reg <= 1'b0;
    else stall_reg <= !stall_reg;
    if (rst_b && memReqReady) begin
      if (memReq.op == svq_pkg::SVQ_MEM_RD16) begin
        memRdValid <= 1'b1;
        memRdData <= mem[wi];
        last_reg <= mem[wi];
      end else begin
        mem[wi] <= memReq.data[15:0];
        if (memReq.op == svq_pkg::SVQ_MEM_WR32) mem[wi+1] <= memReq.data[31:16];
      end
    end
  end
endmodule

// File: verif/tb_top.sv
// self-checking bench for the split ring engine
`timescale 1ns/1ps
module tb_top;
  logic mclk = 1'b0, rst_b = 1'b0, enable, featEventIdx, featInOrder;
  logic suppressAvailNote, availNotifyPin, headReady, cplValid, slow;
  logic [15:0] queueSize, availEventValue, headOut, usedIdxOut, lastAvailOut;
  logic [63:0] availBase, usedBase;
  logic [15:0] memRdData, heads[$];
  logic memReqValid, memReqReady, memRdValid, headValid, cplReady;
  logic usedNotify, configError;
  svq_pkg::svq_mem_req_type memReq;
  svq_pkg::svq_cpl_type     cplIn;
  int num_errors = 0, num_checks = 0, nNote = 0, cyc = 0;

  svq_ring_engine uut (.mclk(mclk), .rst_b(rst_b), .enable(enable),
    .featEventIdx(featEventIdx), .featInOrder(featInOrder),
    .queueSize(queueSize), .availBase(availBase), .usedBase(usedBase),
    .suppressAvailNote(suppressAvailNote), .availEventValue(availEventValue),
    .availNotifyPin(availNotifyPin), .memReq(memReq),
    .memReqValid(memReqValid), .memReqReady(memReqReady),
    .memRdData(memRdData), .memRdValid(memRdValid), .headOut(headOut),
    .headValid(headValid), .headReady(headReady), .cplIn(cplIn),
    .cplValid(cplValid), .cplReady(cplReady), .usedNotify(usedNotify),
    .usedIdxOut(usedIdxOut), .lastAvailOut(lastAvailOut),
    .configError(configError));
  svq_guest_mem m (.mclk(mclk), .rst_b(rst_b), .slow(slow), .memReq(memReq),
    .memReqValid(memReqValid), .memReqReady(memReqReady),
    .memRdData(memRdData), .memRdValid(memRdValid));

  // 100 ns clock
  initial begin
    forever #50 mclk = ~mclk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic end_of_test();
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // reset with new features; enable from the third edge after release
  task automatic restart(input logic ev, input logic io, input logic sup);
    rst_b = 1'b0;
    enable = 1'b0;
    featEventIdx = ev;
    featInOrder = io;
    suppressAvailNote = sup;
    tick(10);
    m.clear();
    nNote = 0;
    heads.delete();
    rst_b = 1'b1;
    tick(2);
    enable = 1'b1;
    tick(40);
  endtask

  // entry first, then the index moves forward
  task automatic offer(input int slot, input logic [15:0] h, input int idx);
    m.mem[2+slot] = h;
    m.mem[1] = 16'(idx);
  endtask

  // hand one completion over, held until the fifo takes it
  task automatic complete(input logic [31:0] h, l, input logic [15:0] c);
    int k = 0;
    cplIn = '{h, l, c};
    cplValid = 1'b1;
    while (cplReady !== 1'b1 && k < 50) begin
      tick(1);
      k++;
    end
    if (k == 50) num_errors++;
    tick(1);
    cplValid = 1'b0;
    tick(80);
  endtask

  // count every used notification, due or not; cut a hang short
  always @(posedge mclk) begin
    if (usedNotify === 1'b1) nNote++;
    if (headValid === 1'b1 && headReady === 1'b1) heads.push_back(headOut);
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    {enable, featEventIdx, featInOrder, suppressAvailNote} = 4'h0;
    {availNotifyPin, cplValid, slow} = 3'h0;
    headReady = 1'b1;
    cplIn = '0;
    queueSize = 16'h0000;
    availBase = 64'h0000;
    usedBase = 64'h0400;
    availEventValue = 16'h0003;
    tick(10);
    rst_b = 1'b1;
    enable = 1'b1;
    tick(5);
    chk(32'h1, 32'(configError));
    queueSize = 16'h8001;
    tick(5);
    chk(32'h1, 32'(configError));
    queueSize = 16'h0004;
    restart(1'b0, 1'b0, 1'b1);
    chk(32'h1, 32'(m.mem[11'h200]));
    offer(0, 16'h0005, 1);
    offer(1, 16'h0007, 2);
    // doorbells, neither one due while used flags hold 1
    repeat (2) begin
      availNotifyPin = 1'b1;
      tick(3);
      availNotifyPin = 1'b0;
      tick(3);
    end
    tick(40);
    chk(32'h5, 32'(heads[0]));
    chk(32'h7, 32'(heads[1]));
    chk(32'h2, 32'(lastAvailOut));
    complete(32'h5, 32'h40, 16'h1);
    chk(32'h5, {m.mem[11'h203], m.mem[11'h202]});
    chk(32'h40, {m.mem[11'h205], m.mem[11'h204]});
    chk(32'h1, 32'(m.mem[11'h201]));
    chk(32'h1, nNote);
    m.mem[0] = 16'h0001; // driver asks for quiet
    complete(32'h7, 32'h10, 16'h1);
    chk(32'h1, nNote);
    chk(32'h2, 32'(usedIdxOut));
    slow = 1'b1;
    restart(1'b1, 1'b1, 1'b0);
    chk(32'h3, 32'(m.mem[11'h212]));
    m.mem[0] = 16'h0001; // stray low bit, must be ignored
    m.mem[6] = 16'h0001;
    headReady = 1'b0;
    for (int i = 0; i < 4; i++) offer(i, 16'(i + 1), i + 1);
    availNotifyPin = 1'b1; // idx 3 met the threshold
    tick(80);
    {availNotifyPin, headReady} = 2'b01;
    complete(32'h3, 32'h20, 16'h3);
    chk(32'h3, {m.mem[11'h203], m.mem[11'h202]});
    chk(32'h3, 32'(usedIdxOut));
    chk(32'h1, nNote);
    complete(32'h4, 32'h8, 16'h1);
    chk(32'h4, {m.mem[11'h20f], m.mem[11'h20e]});
    chk(32'h1, nNote);
    chk(32'h4, 32'(usedIdxOut));
    end_of_test();
  end
endmodule

bind svq_ring_engine svq_ring_checker chk (.mclk(mclk), .rst_b(rst_b),
  .featEventIdx(featEventIdx), .queueSize(queueSize), .usedBase(usedBase),
  .memReq(memReq), .memReqValid(memReqValid), .memReqReady(memReqReady),
  .headOut(headOut), .headValid(headValid), .headReady(headReady),
  .usedNotify(usedNotify), .usedIdxOut(usedIdxOut),
  .configError(configError));
